// [hw/can_wake_pkg.sv]
package can_wake_pkg;

    // =========================================================
    // timing
    localparam int CLK_PERIOD_NS      = 100;
    // 1 us sits inside both limits and below the 2 us bit pair
    localparam int WAKE_FILTER_NS     = 1000;
    localparam int WAKE_FILTER_CYC    = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_TIMEOUT_NS    = 1000000;
    localparam int WAKE_TIMEOUT_CYC   = WAKE_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int MODE_CHANGE_NS     = 20000;
    localparam int MODE_CHANGE_CYC    = MODE_CHANGE_NS / CLK_PERIOD_NS;
    localparam int DOMINANT_LIMIT_NS  = 1200000;
    localparam int DOMINANT_LIMIT_CYC = (DOMINANT_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // =========================================================
    // reset values
    localparam logic RXD_RESET        = 1'b1;
    localparam logic RXD_OE_RESET     = 1'b0;
    localparam logic STANDBY_RESET    = 1'b1;

    // =========================================================
    // states
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_STANDBY,
        MODE_PROTECT,
        MODE_RECOVER
    } mode_t;

    typedef enum logic [1:0] {
        WAKE_IDLE,
        WAKE_FIRST_DOM,
        WAKE_RECESSIVE,
        WAKE_DONE
    } wake_t;

endpackage

// [hw/bus_state_filter.sv]
`timescale 1ns/1ps
module bus_state_filter
    import can_wake_pkg::*;
#(
    parameter int FILT_CYC = WAKE_FILTER_CYC
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic enable_in,
    input  wire logic dom_in,
    input  wire logic rec_in,
    output logic      dom_hit_out,
    output logic      rec_hit_out,
    output logic      dom_held_out
);
    localparam int CW = $clog2(FILT_CYC + 2);

    logic [1:0]    cls;
    logic [1:0]    prev_cls;
    logic [CW-1:0] cnt;
    wire  [1:0]    cur_cls  = dom_in ? 2'h1 : (rec_in ? 2'h2 : 2'h0);
    wire           same     = enable_in && (cur_cls == prev_cls) && (cur_cls != 2'h0);
    wire           reached  = (cnt == CW'(FILT_CYC));
    // held strictly longer than the filter time before it counts
    wire           next_hit = same && reached;

    assign cls = cur_cls;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_cls     <= 2'h0;
            cnt          <= '0;
            dom_hit_out  <= 1'b0;
            rec_hit_out  <= 1'b0;
            dom_held_out <= 1'b0;
        end else begin
            prev_cls     <= enable_in ? cls : 2'h0;
            // undefined levels restart the count, not the pattern
            cnt          <= !same ? '0 : (reached ? cnt + CW'(1) : (cnt > CW'(FILT_CYC) ? cnt : cnt + CW'(1)));
            dom_hit_out  <= next_hit && (cls == 2'h1);
            rec_hit_out  <= next_hit && (cls == 2'h2);
            dom_held_out <= same && (cls == 2'h1) && (cnt >= CW'(FILT_CYC));
        end
    end
endmodule

// [hw/can_transceiver_mode_wake_ctrl.sv]
`timescale 1ns/1ps
module can_transceiver_mode_wake_ctrl
    import can_wake_pkg::*;
#(
    parameter int WAKE_TIMEOUT   = WAKE_TIMEOUT_CYC,
    parameter int DOMINANT_LIMIT = DOMINANT_LIMIT_CYC,
    parameter int MODE_CHANGE    = MODE_CHANGE_CYC,
    parameter int FILTER         = WAKE_FILTER_CYC
) (
    input  wire logic clk_sys_in,
    input  wire logic arst_n_in,
    input  wire logic txd_in,
    input  wire logic txd_float_in,
    input  wire logic standby_select_in,
    input  wire logic standby_select_float_in,
    input  wire logic main_rx_dom_in,
    input  wire logic main_rx_rec_in,
    input  wire logic lp_rx_dom_in,
    input  wire logic lp_rx_rec_in,
    input  wire logic main_supply_low_in,
    input  wire logic io_supply_low_in,
    input  wire logic overtemp_above_in,
    input  wire logic overtemp_cooled_in,
    output logic      driver_dominant_out,
    output logic      bias_mid_out,
    output logic      bias_ground_out,
    output logic      main_rx_en_out,
    output logic      lowpower_rx_en_out,
    output logic      rxd_out,
    output logic      rxd_oe_out,
    output logic      standby_out,
    output logic      protected_out,
    output logic      thermal_shutdown_out,
    output logic      dominant_timeout_out,
    output logic      wake_pattern_out
);
    localparam int TW = $clog2(WAKE_TIMEOUT + 2);
    localparam int DW = $clog2(DOMINANT_LIMIT + 2);
    localparam int MW = $clog2(MODE_CHANGE + 2);

    // =========================================================
    // reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // =========================================================
    // pin fail-safe bias
    // weak pull-ups: open pins land recessive and standby
    wire txd_eff = txd_in | txd_float_in;
    wire stb_eff = standby_select_in | standby_select_float_in;

    // =========================================================
    // operating mode
    mode_t         mode;
    mode_t         next_mode;
    logic [MW-1:0] mode_cnt;
    logic [MW-1:0] next_mode_cnt;
    wire           mode_done = (mode_cnt >= MW'(MODE_CHANGE));

    always_comb begin
        next_mode     = mode;
        next_mode_cnt = '0;
        if (io_supply_low_in) begin
            next_mode = MODE_PROTECT;
        end else if (main_supply_low_in) begin
            // standby needs only the io supply
            next_mode = stb_eff ? MODE_STANDBY : MODE_PROTECT;
        end else begin
            case (mode)
                MODE_PROTECT: begin
                    next_mode = MODE_RECOVER;
                end
                MODE_RECOVER: begin
                    // hold off until the mode change time has run
                    next_mode_cnt = mode_cnt + MW'(1);
                    if (mode_done) begin
                        next_mode     = stb_eff ? MODE_STANDBY : MODE_NORMAL;
                        next_mode_cnt = '0;
                    end
                end
                MODE_NORMAL, MODE_STANDBY: begin
                    // one cycle of latency, far inside 20 us
                    next_mode = stb_eff ? MODE_STANDBY : MODE_NORMAL;
                end
                default: begin
                    next_mode = MODE_PROTECT;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            mode     <= MODE_PROTECT;
            mode_cnt <= '0;
        end else begin
            mode     <= next_mode;
            mode_cnt <= next_mode_cnt;
        end
    end

    wire in_normal  = (mode == MODE_NORMAL);
    wire in_standby = (mode == MODE_STANDBY);

    // =========================================================
    // thermal shutdown with hysteresis
    logic thermal_shutdown;
    // set on the upper trip, released only once cooled below it
    wire  next_tsd = overtemp_above_in | (thermal_shutdown & ~overtemp_cooled_in);

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            thermal_shutdown <= 1'b0;
        end else begin
            thermal_shutdown <= next_tsd;
        end
    end

    // =========================================================
    // transmit dominant timeout
    logic          txd_prev;
    logic          dto_armed;
    logic          dominant_timeout;
    logic [DW-1:0] dto_cnt;
    wire           txd_fall  = in_normal && txd_prev && !txd_eff;
    wire           dto_run   = in_normal && !txd_eff && (dto_armed || txd_fall);
    wire           dto_hit   = dto_run && (dto_cnt >= DW'(DOMINANT_LIMIT - 1));
    // a falling edge arms, a recessive transmit level clears
    wire           next_dto  = in_normal && !txd_eff && (dominant_timeout || dto_hit);
    wire [DW-1:0]  next_dcnt = (dto_run && !dto_hit) ? dto_cnt + DW'(1) : '0;

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            txd_prev  <= 1'b1;
            dto_armed <= 1'b0;
            dominant_timeout       <= 1'b0;
            dto_cnt   <= '0;
        end else begin
            txd_prev  <= txd_eff;
            dto_armed <= dto_run;
            dominant_timeout       <= next_dto;
            dto_cnt   <= next_dcnt;
        end
    end

    // =========================================================
    // standby bus monitor
    logic dom_hit;
    logic rec_hit;
    logic dom_held;

    // only the low-power receiver feeds the monitor
    bus_state_filter #(
        .FILT_CYC (FILTER)
    ) u_filter (
        .clk_in       (clk_sys_in),
        .rst_n_in     (rst_n),
        .enable_in    (in_standby),
        .dom_in       (lp_rx_dom_in),
        .rec_in       (lp_rx_rec_in),
        .dom_hit_out  (dom_hit),
        .rec_hit_out  (rec_hit),
        .dom_held_out (dom_held)
    );

    wake_t         wake;
    wake_t         next_wake;
    logic [TW-1:0] wake_cnt;
    wire           wake_expired = (wake_cnt >= TW'(WAKE_TIMEOUT));
    wire           wake_timing  = (wake == WAKE_FIRST_DOM) || (wake == WAKE_RECESSIVE);
    wire [TW-1:0]  next_wake_cnt;

    always_comb begin
        next_wake = wake;
        if (!in_standby) begin
            next_wake = WAKE_IDLE;
        end else if (wake_timing && wake_expired) begin
            // too slow: start over, no wake reported
            next_wake = WAKE_IDLE;
        end else begin
            // unfiltered traffic between steps changes nothing
            case (wake)
                WAKE_IDLE:      next_wake = dom_hit ? WAKE_FIRST_DOM : WAKE_IDLE;
                WAKE_FIRST_DOM: next_wake = rec_hit ? WAKE_RECESSIVE : WAKE_FIRST_DOM;
                WAKE_RECESSIVE: next_wake = dom_hit ? WAKE_DONE : WAKE_RECESSIVE;
                WAKE_DONE:      next_wake = WAKE_DONE;
                default:        next_wake = WAKE_IDLE;
            endcase
        end
    end

    // timer starts with the first filtered dominant
    assign next_wake_cnt = (in_standby && wake_timing && !wake_expired)
                         ? wake_cnt + TW'(1) : '0;

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            wake     <= WAKE_IDLE;
            wake_cnt <= '0;
        end else begin
            wake     <= next_wake;
            wake_cnt <= next_wake_cnt;
        end
    end

    wire woken = (next_wake == WAKE_DONE);

    // =========================================================
    // receive output
    logic rxd_normal;
    // undefined differential band keeps the last level
    wire  next_rxd_normal = main_rx_dom_in ? 1'b0 : (main_rx_rec_in ? 1'b1 : rxd_normal);

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            rxd_normal <= RXD_RESET;
        end else begin
            rxd_normal <= next_rxd_normal;
        end
    end

    logic next_rxd;

    always_comb begin
        case (next_mode)
            // follows the bus, also during overtemp or timeout
            MODE_NORMAL:  next_rxd = next_rxd_normal;
            // low only over filtered dominants after wake
            MODE_STANDBY: next_rxd = !(woken && dom_held);
            default:      next_rxd = 1'b1;
        endcase
    end

    // =========================================================
    // driver and bias
    // transmit path blocked by standby, overtemp and timeout
    wire next_drv = (next_mode == MODE_NORMAL) && !txd_eff && !next_tsd && !next_dto;
    wire next_mid = (next_mode == MODE_NORMAL);
    wire next_gnd = (next_mode == MODE_STANDBY);

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            driver_dominant_out  <= 1'b0;
            bias_mid_out         <= 1'b0;
            bias_ground_out      <= 1'b0;
            main_rx_en_out       <= 1'b0;
            lowpower_rx_en_out   <= 1'b0;
            rxd_out              <= RXD_RESET;
            rxd_oe_out           <= RXD_OE_RESET;
            standby_out          <= STANDBY_RESET;
            protected_out        <= 1'b1;
            thermal_shutdown_out <= 1'b0;
            dominant_timeout_out <= 1'b0;
            wake_pattern_out     <= 1'b0;
        end else begin
            driver_dominant_out  <= next_drv;
            bias_mid_out         <= next_mid;
            bias_ground_out      <= next_gnd;
            main_rx_en_out       <= next_mid;
            lowpower_rx_en_out   <= next_gnd;
            rxd_out              <= next_rxd;
            // io supply low releases the receive pin
            rxd_oe_out           <= !io_supply_low_in;
            standby_out          <= next_gnd;
            protected_out        <= (next_mode == MODE_PROTECT) || (next_mode == MODE_RECOVER);
            thermal_shutdown_out <= next_tsd;
            dominant_timeout_out <= next_dto;
            wake_pattern_out     <= woken;
        end
    end
endmodule

// [bench/can_ctrl_monitor.sv]
`timescale 1ns/1ps
// ==========
// port checks
module can_ctrl_monitor
    import can_wake_pkg::*;
#(
    parameter int DOMINANT_LIMIT = DOMINANT_LIMIT_CYC,
    parameter int MODE_CHANGE    = MODE_CHANGE_CYC
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic txd_in,
    input wire logic txd_float_in,
    input wire logic standby_select_in,
    input wire logic standby_select_float_in,
    input wire logic main_rx_dom_in,
    input wire logic main_supply_low_in,
    input wire logic io_supply_low_in,
    input wire logic driver_dominant_out,
    input wire logic bias_mid_out,
    input wire logic bias_ground_out,
    input wire logic main_rx_en_out,
    input wire logic lowpower_rx_en_out,
    input wire logic rxd_out,
    input wire logic rxd_oe_out,
    input wire logic standby_out,
    input wire logic protected_out,
    input wire logic thermal_shutdown_out,
    input wire logic dominant_timeout_out,
    input wire logic wake_pattern_out
);
    logic [1:0]  live;
    logic [19:0] low_cnt;
    logic [19:0] good_cnt;
    wire         tx_eff = txd_in | txd_float_in;
    wire         sb_eff = standby_select_in | standby_select_float_in;
    wire         good   = !main_supply_low_in && !io_supply_low_in;
    // internal reset lags the pin by two edges, so hold checks off meanwhile
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            live     <= 2'h0;
            low_cnt  <= 20'h0;
            good_cnt <= 20'h0;
        end else begin
            live     <= (live == 2'h3) ? live : live + 2'h1;
            low_cnt  <= tx_eff ? 20'h0 : low_cnt + 20'h1;
            good_cnt <= good ? good_cnt + 20'h1 : 20'h0;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in || live != 2'h3);
    sequence s_run;
        !protected_out && good;
    endsequence
    sequence s_tsd_held;
        thermal_shutdown_out && $past(thermal_shutdown_out);
    endsequence
    a_select_mode: assert property (
        s_run |=> standby_out == $past(sb_eff) && bias_mid_out != $past(sb_eff))
        else $error("mode does not follow standby select");
    a_bias_tie: assert property (!protected_out |->
        lowpower_rx_en_out == standby_out && main_rx_en_out == bias_mid_out)
        else $error("receiver enables disagree with mode");
    a_tx_follow: assert property (
        driver_dominant_out |-> !$past(tx_eff) && bias_mid_out)
        else $error("driver dominant without transmit low in normal");
    a_tsd_block: assert property (s_tsd_held |-> !driver_dominant_out)
        else $error("driver active in thermal shutdown");
    a_dto_wait: assert property (
        $rose(dominant_timeout_out) |-> low_cnt >= DOMINANT_LIMIT - 1)
        else $error("dominant timeout too early");
    a_dto_clear: assert property (dominant_timeout_out && tx_eff |=>
        !dominant_timeout_out && !driver_dominant_out)
        else $error("dominant timeout not cleared by recessive");
    a_io_hiz: assert property (io_supply_low_in |=> protected_out &&
        !rxd_oe_out && !driver_dominant_out && !bias_mid_out && !bias_ground_out)
        else $error("pins driven in io undervoltage");
    a_main_prot: assert property (main_supply_low_in && !io_supply_low_in
        && !sb_eff |=> protected_out && rxd_out && rxd_oe_out && !bias_mid_out)
        else $error("main undervoltage state wrong");
    a_recover_wait: assert property (
        $fell(protected_out) |-> good_cnt >= MODE_CHANGE)
        else $error("protected state left before mode change time");
    a_wake_rxd: assert property (
        bias_ground_out && $fell(rxd_out) |-> ##[0:1] wake_pattern_out)
        else $error("rxd low in standby without wake");
    a_wake_clear: assert property (
        !bias_ground_out && !$past(bias_ground_out) |-> !wake_pattern_out)
        else $error("wake flag kept outside standby");
    a_rx_normal: assert property (bias_mid_out && main_rx_dom_in |=>
        !rxd_out || !bias_mid_out)
        else $error("rxd not low on dominant");
    c_wake: cover property (wake_pattern_out);
endmodule

bind can_transceiver_mode_wake_ctrl can_ctrl_monitor #(
    .DOMINANT_LIMIT(DOMINANT_LIMIT),
    .MODE_CHANGE   (MODE_CHANGE)
) can_ctrl_monitor_i (.*);

// [bench/can_host_model.sv]
`timescale 1ns/1ps
// ==========
// protocol controller on the logic side
module can_host_model (
    input  wire logic clk_in,
    input  wire logic rxd_in,
    input  wire logic standby_in,
    input  wire logic protected_in,
    input  wire logic tx_bit_in,
    input  wire logic sleep_in,
    output logic      txd_out,
    output logic      standby_select_out
);
    logic woke;
    logic rxd_q;
    logic fall;
    initial begin
        txd_out = 1'b1;
        standby_select_out = 1'b1;
        woke = 1'b0;
        rxd_q = 1'b1;
    end
    // act after the bench's own drive so both see settled values
    always @(posedge clk_in) begin
        #2;
        fall = standby_in && rxd_q && !rxd_in;
        woke = sleep_in && (woke || fall);
        rxd_q = rxd_in;
        txd_out = protected_in | tx_bit_in;
        standby_select_out = sleep_in && !woke;
    end
endmodule

// [bench/can_transceiver_mode_wake_ctrl_tb.sv]
`timescale 1ns/1ps
module can_transceiver_mode_wake_ctrl_tb;
    import can_wake_pkg::*;
    localparam int WAKE_TIMEOUT   = 200;
    localparam int DOMINANT_LIMIT = 100;
    localparam int MODE_CHANGE    = 10;
    localparam int FILTER         = 3;
    logic clk_sys_in, arst_n_in, txd_float_in, standby_select_float_in;
    logic main_rx_dom_in, main_rx_rec_in, lp_rx_dom_in, lp_rx_rec_in;
    logic main_supply_low_in, io_supply_low_in, overtemp_above_in, overtemp_cooled_in;
    logic tx_bit, sleep, txd_in, standby_select_in;
    logic driver_dominant_out, bias_mid_out, bias_ground_out, main_rx_en_out;
    logic lowpower_rx_en_out, rxd_out, rxd_oe_out, standby_out, protected_out;
    logic thermal_shutdown_out, dominant_timeout_out, wake_pattern_out;
    int   n_errors = 0;
    int   checks   = 0;
    can_transceiver_mode_wake_ctrl #(
        .WAKE_TIMEOUT  (WAKE_TIMEOUT),
        .DOMINANT_LIMIT(DOMINANT_LIMIT),
        .MODE_CHANGE   (MODE_CHANGE),
        .FILTER        (FILTER)
    ) can_transceiver_mode_wake_ctrl_i (.*);
    can_host_model can_host_model_i (
        .clk_in            (clk_sys_in),
        .rxd_in            (rxd_out),
        .standby_in        (standby_out),
        .protected_in      (protected_out),
        .tx_bit_in         (tx_bit),
        .sleep_in          (sleep),
        .txd_out           (txd_in),
        .standby_select_out(standby_select_in)
    );
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic cmp(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_range(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, lo);
        end
    endtask
    task automatic wait_mode(input logic sb);
        int n;
        n = 0;
        while ((protected_out !== 1'b0 || standby_out !== sb) && n < 400) begin
            step(1);
            n++;
        end
        cmp(standby_out, sb);
    endtask
    task automatic lp(input logic d, input logic r, input int n);
        lp_rx_dom_in = d;
        lp_rx_rec_in = r;
        step(n);
    endtask
    task automatic summarize();
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_mode();
        wait_mode(1'b0);
        cmp(main_rx_en_out, 1'b1);
        sleep = 1'b1;
        step(3);
        cmp(bias_ground_out, 1'b1);
        tx_bit = 1'b0;
        step(3);
        cmp(driver_dominant_out, 1'b0);
        tx_bit = 1'b1;
        sleep = 1'b0;
        standby_select_float_in = 1'b1;
        step(3);
        cmp(standby_out, 1'b1);
        standby_select_float_in = 1'b0;
        step(3);
        cmp(bias_mid_out, 1'b1);
    endtask
    task automatic t_tx();
        int n;
        tx_bit = 1'b0;
        step(3);
        cmp(driver_dominant_out, 1'b1);
        txd_float_in = 1'b1;
        step(2);
        cmp(driver_dominant_out, 1'b0);
        txd_float_in = 1'b0;
        n = 0;
        while (dominant_timeout_out !== 1'b1 && n < 300) begin
            step(1);
            n++;
        end
        cmp_range(n, DOMINANT_LIMIT - 2, DOMINANT_LIMIT + 2);
        cmp(driver_dominant_out, 1'b0);
        main_rx_dom_in = 1'b1;
        main_rx_rec_in = 1'b0;
        step(2);
        cmp(rxd_out, 1'b0);
        main_rx_dom_in = 1'b0;
        tx_bit = 1'b1;
        step(3);
        cmp(rxd_out, 1'b0);
        cmp(dominant_timeout_out, 1'b0);
        main_rx_rec_in = 1'b1;
        tx_bit = 1'b0;
        step(3);
        cmp(rxd_out, 1'b1);
        cmp(driver_dominant_out, 1'b1);
    endtask
    task automatic overtemp_threshold();
        overtemp_above_in = 1'b1;
        overtemp_cooled_in = 1'b0;
        step(3);
        cmp(driver_dominant_out, 1'b0);
        cmp(bias_mid_out, 1'b1);
        overtemp_above_in = 1'b0;
        step(3);
        cmp(thermal_shutdown_out, 1'b1);
        overtemp_cooled_in = 1'b1;
        step(3);
        cmp(driver_dominant_out, 1'b1);
        tx_bit = 1'b1;
    endtask
    task automatic t_supply();
        int n;
        io_supply_low_in = 1'b1;
        step(2);
        cmp(rxd_oe_out, 1'b0);
        cmp(bias_mid_out, 1'b0);
        io_supply_low_in = 1'b0;
        wait_mode(1'b0);
        sleep = 1'b1;
        step(3);
        main_supply_low_in = 1'b1;
        step(3);
        cmp(bias_ground_out, 1'b1);
        sleep = 1'b0;
        step(3);
        cmp(protected_out, 1'b1);
        cmp(rxd_oe_out, 1'b1);
        cmp(rxd_out, 1'b1);
        main_supply_low_in = 1'b0;
        n = 0;
        while (protected_out !== 1'b0 && n < 100) begin
            step(1);
            n++;
        end
        cmp_range(n, MODE_CHANGE, MODE_CHANGE + 4);
    endtask
    task automatic t_wake();
        sleep = 1'b1;
        standby_select_float_in = 1'b1;
        step(4);
        lp(1'b1, 1'b0, 8);
        lp(1'b0, 1'b0, 2);
        lp(1'b0, 1'b1, 8);
        lp(1'b1, 1'b0, 2);
        lp(1'b0, 1'b1, 8);
        cmp(rxd_out, 1'b1);
        lp(1'b1, 1'b0, 8);
        cmp(wake_pattern_out, 1'b1);
        cmp(rxd_out, 1'b0);
        lp(1'b0, 1'b1, 4);
        cmp(rxd_out, 1'b1);
        lp(1'b1, 1'b0, 2);
        lp(1'b0, 1'b1, 4);
        cmp(rxd_out, 1'b1);
        lp(1'b1, 1'b0, 8);
        cmp(rxd_out, 1'b0);
        lp(1'b0, 1'b1, 4);
        standby_select_float_in = 1'b0;
        step(4);
        cmp(standby_out, 1'b0);
        sleep = 1'b0;
        step(3);
        sleep = 1'b1;
        standby_select_float_in = 1'b1;
        step(4);
        cmp(wake_pattern_out, 1'b0);
        lp(1'b1, 1'b0, 8);
        lp(1'b0, 1'b1, 8);
        lp(1'b0, 1'b0, WAKE_TIMEOUT + 20);
        lp(1'b1, 1'b0, 8);
        cmp(wake_pattern_out, 1'b0);
        lp(1'b0, 1'b1, 8);
        lp(1'b1, 1'b0, 8);
        cmp(wake_pattern_out, 1'b1);
        lp(1'b0, 1'b1, 4);
    endtask
    initial begin
        #2000000;
        n_errors++;
        summarize();
    end
    initial begin
        {arst_n_in, txd_float_in, standby_select_float_in, main_rx_dom_in} = 4'h0;
        {lp_rx_dom_in, main_supply_low_in, io_supply_low_in, overtemp_above_in} = 4'h0;
        {main_rx_rec_in, lp_rx_rec_in, overtemp_cooled_in, tx_bit} = 4'hf;
        sleep = 1'b0;
        step(10);
        cmp(rxd_oe_out, 1'b0);
        arst_n_in = 1'b1;
        t_mode();
        t_tx();
        overtemp_threshold();
        t_supply();
        t_wake();
        summarize();
    end
endmodule
